//--- logic/mac_irq_pkg.sv
package mac_irq_pkg;

    // -----------------------------------------------------------------
    // Register map (byte addresses, one word each)
    // -----------------------------------------------------------------
    localparam logic [7:0] ADDR_GLOBAL_CTRL   = 8'h04;
    localparam logic [7:0] ADDR_PACING_COUNT  = 8'h08;
    localparam logic [7:0] ADDR_TX_RAW        = 8'h10;
    localparam logic [7:0] ADDR_TX_MASKED     = 8'h14;
    localparam logic [7:0] ADDR_TX_EN_SET     = 8'h18;
    localparam logic [7:0] ADDR_TX_EN_CLEAR   = 8'h1C;
    localparam logic [7:0] ADDR_RX_RAW        = 8'h20;
    localparam logic [7:0] ADDR_RX_MASKED     = 8'h24;
    localparam logic [7:0] ADDR_RX_EN_SET     = 8'h28;
    localparam logic [7:0] ADDR_RX_EN_CLEAR   = 8'h2C;
    localparam logic [7:0] ADDR_MAC_RAW       = 8'h30;
    localparam logic [7:0] ADDR_MAC_MASKED    = 8'h34;
    localparam logic [7:0] ADDR_MAC_EN_SET    = 8'h38;
    localparam logic [7:0] ADDR_MAC_EN_CLEAR  = 8'h3C;
    localparam logic [7:0] ADDR_LINK_RAW      = 8'h40;
    localparam logic [7:0] ADDR_LINK_MASKED   = 8'h44;
    localparam logic [7:0] ADDR_LINK_ENABLE   = 8'h48;
    localparam logic [7:0] ADDR_USER_RAW      = 8'h50;
    localparam logic [7:0] ADDR_USER_MASKED   = 8'h54;
    localparam logic [7:0] ADDR_USER_EN_SET   = 8'h58;
    localparam logic [7:0] ADDR_USER_EN_CLEAR = 8'h5C;
    localparam logic [7:0] ADDR_TX_CP_BASE    = 8'h80;
    localparam logic [7:0] ADDR_RX_CP_BASE    = 8'hA0;

    // -----------------------------------------------------------------
    // Fields, widths, reset values
    // -----------------------------------------------------------------
    localparam int         CHANNELS       = 8;
    localparam int         SELECTORS      = 2;
    localparam int         PACE_WIDTH     = 17;
    localparam int         BIT_STAT       = 0;
    localparam int         BIT_HOSTERR    = 1;
    localparam int         BIT_GLOBAL_EN  = 0;
    localparam logic [16:0] PACE_RESET    = 17'h00000;
    localparam logic [31:0] STAT_THRESHOLD = 32'h80000000;

    typedef struct packed {
        logic        cyc;
        logic        stb;
        logic        we;
        logic [3:0]  sel;
        logic [7:0]  adr;
        logic [31:0] dat;
    } wb_req_t;

    typedef struct packed {
        logic        ack;
        logic [31:0] dat;
    } wb_rsp_t;

    // Per-channel completion pointer write from a DMA engine
    typedef struct packed {
        logic [7:0]  valid;
        logic [2:0]  chan;
        logic [31:0] addr;
    } cp_write_t;

endpackage

//--- logic/mac_mgmt_interrupt_logic.sv
// Overview of operation
// [RULE1] Eight level transmit completion interrupts, sticky
// [RULE2] Transmit enable set/clear; raw and masked readable
// [RULE3] Device pointer write raises transmit interrupt
// [RULE4] Host pointer write clears only on match
// [RULE5] Host pointer writes never change stored pointer
// [RULE6] Host acknowledges with last processed descriptor
// [RULE7] Eight level receive completion interrupts, sticky
// [RULE8] Receive enable set/clear; raw and masked readable
// [RULE9] Device pointer write raises receive interrupt
// [RULE10] Host receive pointer write clears on match
// [RULE11] Counter overflow interrupt when counter top set
// [RULE12] Overflow interrupt follows counter top bits
// [RULE13] Descriptor error sticky until hardware reset
// [RULE14] Descriptor error enable set/clear; status readable
// [RULE15] Transmit descriptor faults flag descriptor error
// [RULE16] Receive descriptor faults flag descriptor error
// [RULE17] Link change sets raw bit per selector
// [RULE18] Masked link bit write-one-to-clear
// [RULE19] Start flag falling edge raises user done
// [RULE20] Masked user bit write-one-to-clear
// [RULE21] Re-enable with pending source gives new edge
// [RULE22] Pacing count register paces combined interrupt
// [RULE23] Global enable low keeps output low
// [RULE24] Enable loads pacing counter; wait for zero
module mac_mgmt_interrupt_logic
    import mac_irq_pkg::*;
#(
    parameter int PACE_DIV = 6
) (
    input  wire logic                  sys_clk,
    input  wire logic                  reset,
    input  wire mac_irq_pkg::wb_req_t  wbReq,
    output logic                       wbAck,
    output logic [31:0]                wbDatOut,
    input  wire mac_irq_pkg::cp_write_t txCpWrite,
    input  wire mac_irq_pkg::cp_write_t rxCpWrite,
    input  wire logic                  counterTopBits,
    input  wire logic [5:0]            txDescFault,
    input  wire logic [1:0]            rxDescFault,
    input  wire logic [1:0]            linkChange,
    input  wire logic [1:0]            userAccessStart,
    output logic                       combinedIrqOutput
);
    import mac_irq_pkg::*;

    default clocking cbIrq @(posedge sys_clk); endclocking
    default disable iff (reset);

    // -----------------------------------------------------------------
    // Bus decode
    // -----------------------------------------------------------------
    function automatic logic hit(input logic [7:0] a, input logic [7:0] r);
        return a == r;
    endfunction

    wire logic        access = wbReq.cyc && wbReq.stb && !wbAck;
    wire logic        wr     = access && wbReq.we && wbReq.sel[0];
    wire logic [7:0]  adr    = wbReq.adr;
    wire logic [31:0] wdat   = wbReq.dat;
    wire logic        txCpHit = adr[7:5] == ADDR_TX_CP_BASE[7:5];
    wire logic        rxCpHit = adr[7:5] == ADDR_RX_CP_BASE[7:5];
    wire logic [2:0]  cpIdx   = adr[4:2];

    // -----------------------------------------------------------------
    // State
    // -----------------------------------------------------------------
    logic [31:0] txCp_q [CHANNELS];
    logic [31:0] rxCp_q [CHANNELS];
    logic [7:0]  txRaw_q, txEn_q, rxRaw_q, rxEn_q;
    logic [1:0]  macEn_q;
    logic        hostErr_q;
    logic [1:0]  linkRaw_q, linkEn_q, userRaw_q, userEn_q, userStart_q;
    logic        globalEn_q, globalEnPrev_q;
    logic [PACE_WIDTH-1:0] paceCount_q, paceTimer_q;
    logic [7:0]  divCnt_q;

    wire logic [7:0] txMasked = txRaw_q & txEn_q;
    wire logic [7:0] rxMasked = rxRaw_q & rxEn_q;
    wire logic       statMasked = counterTopBits && macEn_q[BIT_STAT]; // RULE11
    wire logic       hostMasked = hostErr_q && macEn_q[BIT_HOSTERR];
    wire logic [1:0] macRaw  = {hostErr_q, counterTopBits}; // RULE12
    wire logic [1:0] macMask = {hostMasked, statMasked};
    wire logic [1:0] linkMasked = linkRaw_q & linkEn_q;
    wire logic [1:0] userMasked = userRaw_q & userEn_q;
    wire logic       anySource = |txMasked || |rxMasked || |macMask
                                 || |linkMasked || |userMasked;
    wire logic [1:0] userDone = userStart_q & ~userAccessStart; // RULE19
    wire logic       enableRise = globalEn_q && !globalEnPrev_q;
    wire logic       paceTick = divCnt_q == 8'(PACE_DIV - 1);

    // -----------------------------------------------------------------
    // Completion pointers and channel interrupts
    // -----------------------------------------------------------------
    genvar ch;
    generate
        for (ch = 0; ch < CHANNELS; ch++) begin : gChan
            wire logic txDev = txCpWrite.valid[ch];
            wire logic rxDev = rxCpWrite.valid[ch];
            wire logic txAck = wr && txCpHit && cpIdx == 3'(ch)
                               && wdat == txCp_q[ch];            // RULE4 RULE6
            wire logic rxAck = wr && rxCpHit && cpIdx == 3'(ch)
                               && wdat == rxCp_q[ch];            // RULE10
            always_ff @(posedge sys_clk or posedge reset) begin
                if (reset) begin
                    txCp_q[ch]  <= 32'h00000000;
                    rxCp_q[ch]  <= 32'h00000000;
                    txRaw_q[ch] <= 1'b0;
                    rxRaw_q[ch] <= 1'b0;
                end else begin
                    // Only the DMA side stores pointers
                    if (txDev) txCp_q[ch] <= txCpWrite.addr;     // RULE3 RULE5
                    if (rxDev) rxCp_q[ch] <= rxCpWrite.addr;     // RULE9
                    // Device write wins over a same-cycle acknowledge
                    txRaw_q[ch] <= txDev | (txRaw_q[ch] & ~txAck); // RULE1
                    rxRaw_q[ch] <= rxDev | (rxRaw_q[ch] & ~rxAck); // RULE7
                end
            end
        end
    endgenerate

    // -----------------------------------------------------------------
    // Enables, sticky events
    // -----------------------------------------------------------------
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            txEn_q      <= 8'h00;
            rxEn_q      <= 8'h00;
            macEn_q     <= 2'h0;
            hostErr_q   <= 1'b0;
            linkRaw_q   <= 2'h0;
            linkEn_q    <= 2'h0;
            userRaw_q   <= 2'h0;
            userEn_q    <= 2'h0;
            userStart_q <= 2'h0;
        end else begin
            userStart_q <= userAccessStart;
            if (wr && hit(adr, ADDR_TX_EN_SET)) begin
                txEn_q <= txEn_q | wdat[7:0];          // RULE2
            end
            if (wr && hit(adr, ADDR_TX_EN_CLEAR)) begin
                txEn_q <= txEn_q & ~wdat[7:0];         // RULE2
            end
            if (wr && hit(adr, ADDR_RX_EN_SET)) begin
                rxEn_q <= rxEn_q | wdat[7:0];          // RULE8
            end
            if (wr && hit(adr, ADDR_RX_EN_CLEAR)) begin
                rxEn_q <= rxEn_q & ~wdat[7:0];         // RULE8
            end
            if (wr && hit(adr, ADDR_MAC_EN_SET)) begin
                macEn_q <= macEn_q | wdat[1:0];        // RULE14
            end
            if (wr && hit(adr, ADDR_MAC_EN_CLEAR)) begin
                macEn_q <= macEn_q & ~wdat[1:0];       // RULE14
            end
            if (wr && hit(adr, ADDR_LINK_ENABLE)) begin
                linkEn_q <= wdat[1:0];                 // RULE17
            end
            if (wr && hit(adr, ADDR_USER_EN_SET)) begin
                userEn_q <= userEn_q | wdat[1:0];      // RULE19
            end
            if (wr && hit(adr, ADDR_USER_EN_CLEAR)) begin
                userEn_q <= userEn_q & ~wdat[1:0];     // RULE19
            end
            // Only reset clears it
            if (|txDescFault || |rxDescFault) hostErr_q <= 1'b1; // RULE13 RULE15 RULE16
            // Event set wins over write-one-to-clear
            linkRaw_q <= linkChange | (linkRaw_q & ~(wr && hit(adr,
                         ADDR_LINK_MASKED) ? wdat[1:0] : 2'h0));  // RULE17 RULE18
            userRaw_q <= userDone | (userRaw_q & ~(wr && hit(adr,
                         ADDR_USER_MASKED) ? wdat[1:0] : 2'h0));  // RULE19 RULE20
        end
    end

    // -----------------------------------------------------------------
    // Global enable and pacing
    // -----------------------------------------------------------------
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            globalEn_q     <= 1'b0;
            globalEnPrev_q <= 1'b0;
            paceCount_q    <= PACE_RESET;
            paceTimer_q    <= PACE_RESET;
            divCnt_q       <= 8'h00;
            combinedIrqOutput <= 1'b0;
        end else begin
            globalEnPrev_q <= globalEn_q;
            if (wr && hit(adr, ADDR_GLOBAL_CTRL)) begin
                globalEn_q <= wdat[BIT_GLOBAL_EN];     // RULE21
            end
            if (wr && hit(adr, ADDR_PACING_COUNT)) begin
                paceCount_q <= wdat[16:0];             // RULE22
            end
            divCnt_q <= paceTick ? 8'h00 : divCnt_q + 8'h01;
            if (enableRise) begin
                paceTimer_q <= paceCount_q;            // RULE24
            end else if (paceTick && paceTimer_q != '0) begin
                paceTimer_q <= paceTimer_q - 1'b1;
            end
            // Drops whenever disabled so re-enable makes a fresh edge
            combinedIrqOutput <= globalEn_q && anySource
                                 && paceTimer_q == '0 && !enableRise;  // RULE21 RULE23
        end
    end

    // -----------------------------------------------------------------
    // Read mux and ack
    // -----------------------------------------------------------------
    logic [31:0] rdData;
    always_comb begin
        rdData = 32'h00000000;
        case (1'b1)
            hit(adr, ADDR_GLOBAL_CTRL):  rdData = {31'h0, globalEn_q};
            hit(adr, ADDR_PACING_COUNT): rdData = {15'h0, paceCount_q};
            hit(adr, ADDR_TX_RAW):       rdData = {24'h0, txRaw_q};
            hit(adr, ADDR_TX_MASKED):    rdData = {24'h0, txMasked};
            hit(adr, ADDR_TX_EN_SET),
            hit(adr, ADDR_TX_EN_CLEAR):  rdData = {24'h0, txEn_q};
            hit(adr, ADDR_RX_RAW):       rdData = {24'h0, rxRaw_q};
            hit(adr, ADDR_RX_MASKED):    rdData = {24'h0, rxMasked};
            hit(adr, ADDR_RX_EN_SET),
            hit(adr, ADDR_RX_EN_CLEAR):  rdData = {24'h0, rxEn_q};
            hit(adr, ADDR_MAC_RAW):      rdData = {30'h0, macRaw};
            hit(adr, ADDR_MAC_MASKED):   rdData = {30'h0, macMask};
            hit(adr, ADDR_MAC_EN_SET),
            hit(adr, ADDR_MAC_EN_CLEAR): rdData = {30'h0, macEn_q};
            hit(adr, ADDR_LINK_RAW):     rdData = {30'h0, linkRaw_q};
            hit(adr, ADDR_LINK_MASKED):  rdData = {30'h0, linkMasked};
            hit(adr, ADDR_LINK_ENABLE):  rdData = {30'h0, linkEn_q};
            hit(adr, ADDR_USER_RAW):     rdData = {30'h0, userRaw_q};
            hit(adr, ADDR_USER_MASKED):  rdData = {30'h0, userMasked};
            hit(adr, ADDR_USER_EN_SET),
            hit(adr, ADDR_USER_EN_CLEAR): rdData = {30'h0, userEn_q};
            txCpHit:                     rdData = txCp_q[cpIdx];
            rxCpHit:                     rdData = rxCp_q[cpIdx];
            default:                     rdData = 32'h00000000;
        endcase
    end

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            wbAck    <= 1'b0;
            wbDatOut <= 32'h00000000;
        end else begin
            wbAck    <= access;
            wbDatOut <= access ? rdData : 32'h00000000;
        end
    end

    // -----------------------------------------------------------------
    // Checks
    // -----------------------------------------------------------------
    a_output_disabled: assert property (@(posedge sys_clk) disable iff (reset) // RULE23
        !globalEn_q |=> !combinedIrqOutput)
        else $error("combined output high while disabled");
    a_tx_raise: assert property (@(posedge sys_clk) disable iff (reset) // RULE3
        txCpWrite.valid[0] |=> txRaw_q[0])
        else $error("tx device write did not raise");
    a_rx_raise: assert property (@(posedge sys_clk) disable iff (reset) // RULE9
        rxCpWrite.valid[0] |=> rxRaw_q[0])
        else $error("rx device write did not raise");
    a_tx_ptr_kept: assert property (@(posedge sys_clk) disable iff (reset) // RULE5
        !txCpWrite.valid[0] |=> $stable(txCp_q[0]))
        else $error("tx pointer changed without device write");
    a_host_err_sticky: assert property (@(posedge sys_clk) disable iff (reset) // RULE13
        hostErr_q |=> hostErr_q)
        else $error("descriptor error cleared");
    a_tx_hold: assert property (@(posedge sys_clk) disable iff (reset) // RULE1
        txRaw_q[0] && !(wr && txCpHit) |=> txRaw_q[0])
        else $error("tx interrupt dropped without ack");
    a_pace_load: assert property (@(posedge sys_clk) disable iff (reset) // RULE24
        enableRise |=> paceTimer_q == $past(paceCount_q))
        else $error("pacing counter not loaded");
    a_pace_block: assert property (@(posedge sys_clk) disable iff (reset) // RULE22
        paceTimer_q != '0 |=> !combinedIrqOutput)
        else $error("interrupt issued during pacing");
    a_user_done: assert property (@(posedge sys_clk) disable iff (reset) // RULE19
        $fell(userAccessStart[0]) |=> userRaw_q[0])
        else $error("user done not captured");
    a_link_raw: assert property (@(posedge sys_clk) disable iff (reset) // RULE17
        linkChange[1] |=> linkRaw_q[1])
        else $error("link change not captured");

    // -----------------------------------------------------------------
    // Multi-step checks
    // -----------------------------------------------------------------
    sequence s_enable_rise;
        !globalEn_q ##1 globalEn_q;
    endsequence

    sequence s_rearm_active;
        s_enable_rise ##0 (paceCount_q == '0) ##1 (globalEn_q && anySource);
    endsequence

    a_rise_gap: assert property ( // RULE21
        s_enable_rise |=> !combinedIrqOutput)
        else $error("no low cycle after enable");
    a_reenable_edge: assert property ( // RULE21
        s_rearm_active |=> combinedIrqOutput)
        else $error("pending source gave no new edge");
    a_rx_hold: assert property ( // RULE7
        rxRaw_q[0] && !(wr && rxCpHit) |=> rxRaw_q[0])
        else $error("rx interrupt dropped without ack");
    a_tx_match: assert property ( // RULE4
        wr && txCpHit && cpIdx == 3'h0 && wdat == txCp_q[0]
        && !txCpWrite.valid[0] |=> !txRaw_q[0])
        else $error("tx matching ack did not clear");
    a_tx_differ: assert property ( // RULE4
        wr && txCpHit && cpIdx == 3'h0 && wdat != txCp_q[0]
        && txRaw_q[0] |=> txRaw_q[0])
        else $error("tx differing ack cleared");
    a_rx_match: assert property ( // RULE10
        wr && rxCpHit && cpIdx == 3'h0 && wdat == rxCp_q[0]
        && !rxCpWrite.valid[0] |=> !rxRaw_q[0])
        else $error("rx matching ack did not clear");
    a_rx_differ: assert property ( // RULE10
        wr && rxCpHit && cpIdx == 3'h0 && wdat != rxCp_q[0]
        && rxRaw_q[0] |=> rxRaw_q[0])
        else $error("rx differing ack cleared");
    a_tx_en_set: assert property ( // RULE2
        wr && hit(adr, ADDR_TX_EN_SET)
        |=> &(txEn_q | ~$past(wdat[7:0])))
        else $error("tx enable set lost");
    a_tx_en_clr: assert property ( // RULE2
        wr && hit(adr, ADDR_TX_EN_CLEAR)
        |=> !(|(txEn_q & $past(wdat[7:0]))))
        else $error("tx enable clear lost");
    a_err_tx: assert property ( // RULE15
        |txDescFault |=> hostErr_q)
        else $error("tx descriptor fault not flagged");
    a_err_rx: assert property ( // RULE16
        |rxDescFault |=> hostErr_q)
        else $error("rx descriptor fault not flagged");
    a_link_clear: assert property ( // RULE18
        wr && hit(adr, ADDR_LINK_MASKED) && wdat[0]
        && !linkChange[0] |=> !linkRaw_q[0])
        else $error("link write-one-to-clear failed");
    a_user_clear: assert property ( // RULE20
        wr && hit(adr, ADDR_USER_MASKED) && wdat[0]
        && !userDone[0] |=> !userRaw_q[0])
        else $error("user write-one-to-clear failed");
    a_pace_step: assert property ( // RULE24
        paceTick && paceTimer_q != '0 && !enableRise
        |=> paceTimer_q == $past(paceTimer_q) - 1'b1)
        else $error("pacing counter did not step");
    a_stat_out: assert property ( // RULE11
        globalEn_q && !enableRise && paceTimer_q == '0 && statMasked
        |=> combinedIrqOutput)
        else $error("statistics source not passed on");

endmodule

//--- test/irq_edge_counter.sv
// -----------------------------------------------------------------
// Interrupt controller input: counts rising edges only
// -----------------------------------------------------------------
module irq_edge_counter (
    input  wire logic sys_clk,
    input  wire logic reset,
    input  wire logic irqLine,
    output int        edgeCount
);
    timeunit 1ns;
    timeprecision 1ps;

    logic irqLine_q;

    // Level alone raises nothing here, as on an edge-triggered core
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            irqLine_q <= 1'b0;
            edgeCount <= 0;
        end else begin
            irqLine_q <= irqLine;
            if (irqLine && !irqLine_q) begin
                edgeCount <= edgeCount + 1;
            end
        end
    end
endmodule

//--- test/mac_mgmt_interrupt_logic_tb.sv
module mac_mgmt_interrupt_logic_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import mac_irq_pkg::*;

    logic        sys_clk   = 1'b0;
    logic        reset     = 1'b1;
    wb_req_t     wbReq     = '0;
    cp_write_t   cpw [2]   = '{default: '0};
    logic        counterTop = 1'b0;
    logic [5:0]  txFault   = 6'h00;
    logic [1:0]  rxFault   = 2'h0;
    logic [1:0]  linkChg   = 2'h0;
    logic [1:0]  userStart = 2'h0;
    logic        wbAck;
    logic [31:0] wbDatOut;
    logic        irqOut;
    int          edges;
    int          nFail     = 0;
    int          testsRun  = 0;
    logic [31:0] seed      = 32'h000046D9;
    logic [31:0] rdv;

    always #2 sys_clk = ~sys_clk;

    mac_mgmt_interrupt_logic #(.PACE_DIV(1)) uut (
        .sys_clk(sys_clk), .reset(reset), .wbReq(wbReq),
        .wbAck(wbAck), .wbDatOut(wbDatOut), .txCpWrite(cpw[0]),
        .rxCpWrite(cpw[1]), .counterTopBits(counterTop),
        .txDescFault(txFault), .rxDescFault(rxFault),
        .linkChange(linkChg), .userAccessStart(userStart),
        .combinedIrqOutput(irqOut));

    irq_edge_counter cpuIrq (.sys_clk(sys_clk), .reset(reset),
        .irqLine(irqOut), .edgeCount(edges));

    // -----------------------------------------------------------------
    // Helpers
    // -----------------------------------------------------------------
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    function automatic logic [31:0] maskedExp(logic [31:0] r, logic [31:0] e);
        return r & e;
    endfunction

    task automatic giveVerdict();
        $display("checks %0d mismatches %0d", testsRun, nFail);
        if (nFail == 0 && testsRun > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic check(input string nm, input logic [31:0] seen, exp);
        testsRun++;
        if (seen !== exp) begin
            nFail++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // Holds the request until ack is sampled, then releases
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        k = 0;
        @(posedge sys_clk);
        wbReq <= '{1'b1, 1'b1, w, 4'hF, a, d};
        do begin
            @(posedge sys_clk);
            k++;
        end while (wbAck !== 1'b1 && k < 20);
        rdv = wbDatOut;
        wbReq <= '0;
        if (k >= 20) nFail++;
    endtask

    task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] e);
        wb(1'b0, a, 32'h0);
        check(nm, rdv, e);
    endtask

    task automatic cpWr(input int s, input int c, input logic [31:0] a);
        @(posedge sys_clk);
        cpw[s] <= '{valid: 8'h01 << c, chan: 3'(c), addr: a};
    endtask

    task automatic rst();
        reset <= 1'b1;
        repeat (8) @(posedge sys_clk);
        reset <= 1'b0;
    endtask

    initial begin
        #300000;
        $display("watchdog expired");
        nFail++;
        giveVerdict();
    end

    // -----------------------------------------------------------------
    // Scenarios
    // -----------------------------------------------------------------
    initial begin
        logic [7:0]  base, cpb;
        logic [31:0] en, a, b;
        int          e0, k;
        rst();
        rchk("ctrl", ADDR_GLOBAL_CTRL, 0);
        rchk("pace", ADDR_PACING_COUNT, {15'h0, PACE_RESET});
        rchk("unmapped", 8'hFC, 0);
        for (int s = 0; s < 2; s++) begin
            base = s ? ADDR_RX_RAW : ADDR_TX_RAW;
            cpb = s ? ADDR_RX_CP_BASE : ADDR_TX_CP_BASE;
            en = rnd() & 32'hFF;
            wb(1'b1, base + 8'h0C, 32'hFF);
            wb(1'b1, base + 8'h08, en);
            rchk("enable", base + 8'h08, en);
            for (int c = 0; c < CHANNELS; c++) begin
                a = rnd();
                b = rnd() ^ 32'h1;
                cpWr(s, c, a);
                cpWr(s, c, b);
                @(posedge sys_clk);
                cpw[s] <= '0;
                rchk("raw", base, 32'h1 << c);
                rchk("masked", base + 8'h04, maskedExp(32'h1 << c, en));
                wb(1'b1, cpb + 8'(4 * c), a);
                rchk("kept", base, 32'h1 << c);
                rchk("pointer", cpb + 8'(4 * c), b);
                wb(1'b1, cpb + 8'(4 * c), b);
                rchk("cleared", base, 0);
            end
            wb(1'b1, base + 8'h0C, en);
            rchk("disabled", base + 8'h08, 0);
            $display("test completion side %0d done", s);
        end
        wb(1'b1, ADDR_MAC_EN_SET, 32'h3);
        counterTop <= 1'b1;
        rchk("stat raw", ADDR_MAC_RAW, 32'h1);
        rchk("stat masked", ADDR_MAC_MASKED, 32'h1);
        wb(1'b1, ADDR_GLOBAL_CTRL, 32'h1);
        repeat (4) @(posedge sys_clk);
        check("irq on", irqOut, 1);
        e0 = edges;
        wb(1'b1, ADDR_GLOBAL_CTRL, 32'h0);
        repeat (2) @(posedge sys_clk);
        check("irq off", irqOut, 0);
        wb(1'b1, ADDR_PACING_COUNT, 32'd20);
        wb(1'b1, ADDR_GLOBAL_CTRL, 32'h1);
        repeat (10) @(posedge sys_clk);
        check("paced", irqOut, 0);
        k = 0;
        while (irqOut !== 1'b1 && k < 40) begin
            @(posedge sys_clk);
            k++;
        end
        @(posedge sys_clk);
        check("new edge", edges, e0 + 1);
        counterTop <= 1'b0;
        repeat (3) @(posedge sys_clk);
        check("stat gone", irqOut, 0);
        rchk("stat raw off", ADDR_MAC_RAW, 0);
        $display("test combined output done");
        for (int f = 0; f < 8; f++) begin
            @(posedge sys_clk);
            if (f < 6) txFault <= 6'h01 << f;
            else rxFault <= 2'h1 << (f - 6);
            @(posedge sys_clk);
            txFault <= 6'h00;
            rxFault <= 2'h0;
            wb(1'b1, ADDR_MAC_EN_SET, 32'h2);
            rchk("err masked", ADDR_MAC_MASKED, 32'h2);
            wb(1'b1, ADDR_MAC_EN_CLEAR, 32'h3);
            wb(1'b1, ADDR_MAC_RAW, 32'h0);
            rchk("err raw", ADDR_MAC_RAW, 32'h2);
            rchk("err off", ADDR_MAC_MASKED, 0);
            rst();
            rchk("err reset", ADDR_MAC_RAW, 0);
        end
        $display("test descriptor errors done");
        for (int s = 0; s < SELECTORS; s++) begin
            wb(1'b1, ADDR_LINK_ENABLE, 32'h1 << s);
            @(posedge sys_clk);
            linkChg <= 2'h1 << s;
            @(posedge sys_clk);
            linkChg <= 2'h0;
            rchk("link raw", ADDR_LINK_RAW, 32'h1 << s);
            rchk("link masked", ADDR_LINK_MASKED, 32'h1 << s);
            wb(1'b1, ADDR_LINK_MASKED, 32'h1 << s);
            rchk("link clear", ADDR_LINK_RAW, 0);
            wb(1'b1, ADDR_USER_EN_SET, 32'h1 << s);
            userStart <= 2'h1 << s;
            repeat (3) @(posedge sys_clk);
            userStart <= 2'h0;
            repeat (2) @(posedge sys_clk);
            rchk("user raw", ADDR_USER_RAW, 32'h1 << s);
            rchk("user masked", ADDR_USER_MASKED, 32'h1 << s);
            wb(1'b1, ADDR_USER_MASKED, 32'h1 << s);
            rchk("user clear", ADDR_USER_MASKED, 0);
        end
        $display("test link and user done");
        giveVerdict();
    end
endmodule
